// >>> core/cpp_params.svh
// Purpose: Constants of the call-progress output block
// Assumes: Included by bare name from the package and the modules
// Notes:   Rates in kHz; cycle counts derive from them
`ifndef CPP_PARAMS_SVH
`define CPP_PARAMS_SVH

// Clock and waveform rates
`define CPP_CLK_KHZ      17'd125000
`define CPP_DS_KHZ       17'd16384
`define CPP_SAMP_KHZ     17'd16
`define CPP_RZ_KHZ       17'd32

// Tick counter geometry, ticks per sample and per return-to-zero period
`define CPP_CNT_W        10
// Accumulator holds a remainder plus one step, above 2^17
`define CPP_ACC_W        18
`define CPP_SAMP_TICKS   (`CPP_DS_KHZ / `CPP_SAMP_KHZ)
`define CPP_RZ_TICKS     (`CPP_DS_KHZ / `CPP_RZ_KHZ)

// Register indices; the byte address is four times the index
`define CPP_IDX_W        8
`define CPP_IDX_CTRL1    8'h01
`define CPP_IDX_CTRL2    8'h02
`define CPP_IDX_STAT     8'h40

// Field positions
`define CPP_B_SR         7
`define CPP_B_MODE_HI    5
`define CPP_B_MODE_LO    4
`define CPP_B_EN         3
`define CPP_B_IRQSEL     7
`define CPP_B_PIN        0
`define CPP_B_SAMP_LO    16

// Waveform codes
`define CPP_MODE_DS      2'h0
`define CPP_MODE_CTR     2'h1
`define CPP_MODE_RZ      2'h2

// Reset values and the NONSEQ transfer code
`define CPP_CTRL1_RST    8'h00
`define CPP_CTRL2_RST    8'h00
`define CPP_HTRANS_NSEQ  2'h2

`endif

// >>> core/cpp_pkg.sv
// Purpose: Types shared by the call-progress output block
// Assumes: cpp_params.svh holds the numbers
// Notes:   Types only
`include "cpp_params.svh"

package cpp_pkg;

  // Control state held by software
  typedef struct packed {
    logic       soft_reset;
    logic [1:0] wave_sel;
    logic       out_en;
    logic       irq_sel;
  } cpp_ctrl_s;

  // Captured AHB address phase
  typedef struct packed {
    logic                    valid;
    logic                    write;
    logic                    mapped;
    logic [`CPP_IDX_W-1:0]   idx;
  } cpp_aphase_s;

  // Tick timing bundle
  typedef struct packed {
    logic                    tick;
    logic                    samp;
    logic [`CPP_CNT_W-1:0]   cnt;
  } cpp_time_s;

endpackage : cpp_pkg

// >>> core/cpp_tick.sv
// Purpose: 16.384 MHz tick and sample phase counter from the bus clock
// Assumes: hclk at 125 MHz; a fractional accumulator sets the tick rate
// Notes:   Soft reset clears the phase so waveforms restart aligned
`timescale 1ns/10ps
`include "cpp_params.svh"

module cpp_tick (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  input  wire logic              soft_rst,
  // Timing out
  output cpp_pkg::cpp_time_s     time_o
);
  import cpp_pkg::*;

  logic [`CPP_ACC_W-1:0] acc_r;
  logic [`CPP_ACC_W-1:0] acc_sum;
  logic                  acc_wrap;
  logic [`CPP_ACC_W-1:0] acc_nxt;
  logic [`CPP_CNT_W-1:0] cnt_r;
  logic [`CPP_CNT_W-1:0] cnt_nxt;
  logic                  tick_r;
  logic                  samp_r;

  // Fractional rate: tick rate = clock * DS / CLK
  assign acc_sum  = acc_r + `CPP_DS_KHZ;
  assign acc_wrap = (acc_sum >= `CPP_CLK_KHZ);
  assign acc_nxt  = acc_wrap ? (acc_sum - `CPP_CLK_KHZ) : acc_sum;
  assign cnt_nxt  = cnt_r + {{(`CPP_CNT_W-1){1'b0}}, 1'b1};

  // Accumulator, tick and phase count
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      acc_r  <= '0;
      cnt_r  <= 10'h000;
      tick_r <= 1'b0;
      samp_r <= 1'b0;
    end else if (soft_rst) begin
      acc_r  <= '0;
      cnt_r  <= 10'h000;
      tick_r <= 1'b0;
      samp_r <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      tick_r <= acc_wrap;
      samp_r <= acc_wrap && (cnt_nxt == 10'h000);
      if (acc_wrap) begin
        cnt_r <= cnt_nxt;
      end
    end
  end

  assign time_o.tick = tick_r;
  assign time_o.samp = samp_r;
  assign time_o.cnt  = cnt_r;

endmodule // cpp_tick

// >>> core/cpp_top.sv
// Purpose: Control 1, Control 2 and status registers and call-progress pulse output over AHB-Lite
// Assumes: Audio inputs come from logic on hclk; single word transfers
// Notes:   Zero wait states; unmapped addresses read zero, answer OKAY
// Operation
// R1: Writing soft reset restores every register default
// R2: Soft reset bit clears itself, reads zero
// R3: Code 00 gives delta-sigma bitstream at 16.384 MHz
// R4: Code 01 gives pulse centred on 16 kHz
// R5: Code 10 falls each 32 kHz, rises by amplitude
// R6: Software picks waveform in bits 5:4, never 11
// R7: Enable sums both audio paths onto output
// R8: Pin select chooses call-progress or interrupt
// R9: Unused control bits ignore writes, read zero
`timescale 1ns/10ps
`include "cpp_params.svh"

module cpp_top (
  // Clock and reset
  input  wire logic              hclk,
  input  wire logic              hresetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  // Audio paths
  input  wire logic [15:0]       tx_audio,
  input  wire logic [15:0]       rx_audio,
  // Interrupt request from the device
  input  wire logic              irq_req,
  // Shared output pin and reset to the rest of the device
  output logic                   call_progress_out,
  output logic                   soft_reset_out
);
  import cpp_pkg::*;

  // Register state
  cpp_ctrl_s             ctrl_r;
  cpp_ctrl_s             ctrl_nxt;
  cpp_aphase_s           aph_r;
  cpp_aphase_s           aph_nxt;
  logic                  sr_r;
  logic [31:0]           hrdata_r;
  logic [31:0]           rd_nxt;
  logic                  hreadyout_r;
  logic                  hresp_r;

  // Datapath state
  cpp_time_s             tim;
  logic [15:0]           samp_r;
  logic [15:0]           ds_acc_r;
  logic                  ds_bit_r;
  logic                  pin_r;

  // Decode wires
  logic                  take;
  logic                  aligned;
  logic                  wr_go;
  logic                  wr_ctrl1;
  logic                  wr_ctrl2;
  logic                  sr_req;

  // Audio wires
  logic [16:0]           sum17;
  logic                  sum_pos_ovf;
  logic                  sum_neg_ovf;
  logic [15:0]           sum_sat;
  logic [15:0]           level;
  logic [16:0]           ds_sum;

  // Waveform wires
  logic [8:0]            width_half;
  logic [`CPP_CNT_W-1:0] cnt_rev;
  logic                  ctr_lead;
  logic                  ctr_trail;
  logic                  ctr_wave;
  logic [8:0]            rz_phase;
  logic                  rz_wave;
  logic                  sel_ds;
  logic                  sel_ctr;
  logic                  sel_rz;
  logic                  wave;
  logic                  pin_nxt;

  // Address phase register hits
  logic                  hit_ctrl1;
  logic                  hit_ctrl2;
  logic                  hit_stat;

  // Write fields of the data phase word
  logic [1:0]            wr_wave;
  logic                  wr_en;
  logic                  wr_irq;

  // Read words of each mapped register
  logic [31:0]           rd_ctrl1;
  logic [31:0]           rd_ctrl2;
  logic [31:0]           rd_stat;
  logic                  rd_go;

  // Defaults of both control words, so single fields can be picked
  localparam logic [7:0] CTRL1_RST = `CPP_CTRL1_RST;
  localparam logic [7:0] CTRL2_RST = `CPP_CTRL2_RST;

  // Word index of a mapped register
  function automatic logic hit(input logic [`CPP_IDX_W-1:0] idx,
                               input logic [`CPP_IDX_W-1:0] want);
    hit = (idx == want);
  endfunction

  // Tick and phase generator
  cpp_tick u_tick (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .soft_rst (sr_r),
    .time_o   (tim)
  );

  // Address phase decode
  assign take    = hsel && hready && (htrans == `CPP_HTRANS_NSEQ);
  assign aligned = (haddr[1:0] == 2'h0) && (haddr[31:10] == 22'h000000);

  // Register hits of the address now on the bus
  assign hit_ctrl1 = hit(haddr[9:2], `CPP_IDX_CTRL1);
  assign hit_ctrl2 = hit(haddr[9:2], `CPP_IDX_CTRL2);
  assign hit_stat  = hit(haddr[9:2], `CPP_IDX_STAT);

  always_comb begin
    aph_nxt        = aph_r;
    aph_nxt.valid  = 1'b0;
    if (hready) begin
      aph_nxt.valid  = take;
      aph_nxt.write  = hwrite;
      aph_nxt.mapped = aligned;
      aph_nxt.idx    = haddr[9:2];
    end
  end

  // Data phase write strobes
  assign wr_go    = aph_r.valid && aph_r.write && aph_r.mapped;
  assign wr_ctrl1 = wr_go && hit(aph_r.idx, `CPP_IDX_CTRL1);
  assign wr_ctrl2 = wr_go && hit(aph_r.idx, `CPP_IDX_CTRL2);
  assign sr_req   = wr_ctrl1 && hwdata[`CPP_B_SR]; // see R1

  // Stored fields of the data phase word; other bits reach no flop
  assign wr_wave  = hwdata[`CPP_B_MODE_HI:`CPP_B_MODE_LO]; // see R6
  assign wr_en    = hwdata[`CPP_B_EN];
  assign wr_irq   = hwdata[`CPP_B_IRQSEL]; // see R9

  // Next control value; soft reset restores defaults
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (sr_r) begin
      ctrl_nxt.wave_sel = CTRL1_RST[`CPP_B_MODE_HI:`CPP_B_MODE_LO]; // see R1
      ctrl_nxt.out_en   = CTRL1_RST[`CPP_B_EN];
      ctrl_nxt.irq_sel  = CTRL2_RST[`CPP_B_IRQSEL];
    end else begin
      if (wr_ctrl1) begin
        // Only the waveform and enable fields are stored
        ctrl_nxt.wave_sel = wr_wave; // see R6 see R9
        ctrl_nxt.out_en   = wr_en;
      end
      if (wr_ctrl2) begin
        ctrl_nxt.irq_sel = wr_irq;
      end
    end
    ctrl_nxt.soft_reset = 1'b0; // see R2
  end

  // Control one word, built from next values so a read after a write sees it
  always_comb begin
    rd_ctrl1                                = 32'h00000000;
    rd_ctrl1[`CPP_B_SR]                     = 1'b0; // see R2
    rd_ctrl1[`CPP_B_MODE_HI:`CPP_B_MODE_LO] = ctrl_nxt.wave_sel;
    rd_ctrl1[`CPP_B_EN]                     = ctrl_nxt.out_en; // see R9
  end

  // Control two word
  always_comb begin
    rd_ctrl2                = 32'h00000000;
    rd_ctrl2[`CPP_B_IRQSEL] = ctrl_nxt.irq_sel;
  end

  // Status word: pin level and held sample
  always_comb begin
    rd_stat                    = 32'h00000000;
    rd_stat[`CPP_B_PIN]        = pin_r;
    rd_stat[31:`CPP_B_SAMP_LO] = samp_r;
  end

  // Read select; unmapped or unaligned words read zero
  assign rd_go  = take && !hwrite && aligned;
  assign rd_nxt = !rd_go    ? 32'h00000000 :
                  hit_ctrl1 ? rd_ctrl1     :
                  hit_ctrl2 ? rd_ctrl2     :
                  hit_stat  ? rd_stat      : 32'h00000000;

  // Bus response registers; zero wait states, always OKAY
  // Ready never drops, so no transfer is ever stretched
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph_r       <= '0;
      hrdata_r    <= 32'h00000000;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end else begin
      aph_r       <= aph_nxt;
      hrdata_r    <= rd_nxt;
      hreadyout_r <= 1'b1;
      hresp_r     <= 1'b0;
    end
  end

  // Control registers and the one-cycle soft reset pulse
  // The pulse also restarts the tick phase and the held sample
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= '0;
      sr_r   <= 1'b0;
    end else begin
      ctrl_r <= ctrl_nxt;
      sr_r   <= sr_req; // see R1 see R2
    end
  end

  // Sum of both audio paths with saturation
  assign sum17   = {tx_audio[15], tx_audio} + {rx_audio[15], rx_audio}; // see R7
  assign sum_pos_ovf = !sum17[16] && sum17[15];
  assign sum_neg_ovf = sum17[16] && !sum17[15];
  assign sum_sat     = sum_pos_ovf ? 16'h7FFF :
                       sum_neg_ovf ? 16'h8000 : sum17[15:0];
  assign level   = {~sum_sat[15], sum_sat[14:0]};

  // Sample held for the pulse-width forms
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      samp_r <= 16'h8000;
    end else if (sr_r) begin
      samp_r <= 16'h8000;
    end else if (tim.samp) begin
      samp_r <= level;
    end
  end

  // First-order delta-sigma: carry out gives the ones density
  assign ds_sum = {1'b0, ds_acc_r} + {1'b0, level};

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ds_acc_r <= 16'h0000;
      ds_bit_r <= 1'b0;
    end else if (sr_r) begin
      ds_acc_r <= 16'h0000;
      ds_bit_r <= 1'b0;
    end else if (tim.tick) begin
      ds_acc_r <= ds_sum[15:0]; // see R3
      ds_bit_r <= ds_sum[16];
    end
  end

  // Balanced pulse: half width each side of the sample boundary
  assign width_half = samp_r[15:7];
  assign cnt_rev    = ~tim.cnt;
  assign ctr_lead   = ({1'b0, cnt_rev} < {2'b00, width_half}); // Tail of the period
  assign ctr_trail  = ({1'b0, tim.cnt} < {2'b00, width_half}); // Head of the next
  assign ctr_wave   = ctr_lead || ctr_trail; // see R4

  // Return-to-zero: low at each period start, rises at amplitude
  assign rz_phase = tim.cnt[8:0];
  assign rz_wave  = (rz_phase > samp_r[15:7]); // see R5

  // Mode decode; the reserved code selects nothing and drives low
  assign sel_ds  = (ctrl_r.wave_sel == `CPP_MODE_DS); // see R3
  assign sel_ctr = (ctrl_r.wave_sel == `CPP_MODE_CTR);
  assign sel_rz  = (ctrl_r.wave_sel == `CPP_MODE_RZ);

  // Waveform select
  assign wave = (sel_ds && ds_bit_r) || (sel_ctr && ctr_wave) || (sel_rz && rz_wave);

  // Pin function: interrupt or gated call-progress stream
  assign pin_nxt = ctrl_r.irq_sel ? irq_req :            // see R8
                   (ctrl_r.out_en ? wave : 1'b0);        // see R7

  // Output pin register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_r <= 1'b0;
    end else if (sr_r) begin
      pin_r <= 1'b0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // Outputs straight from flops
  assign hreadyout         = hreadyout_r;
  assign hrdata            = hrdata_r;
  assign hresp             = hresp_r;
  assign call_progress_out = pin_r;
  assign soft_reset_out    = sr_r; // see R1

endmodule // cpp_top

// >>> bench/cpp_top_asserts.sv
// Purpose: Port assertions for cpp_top
// Assumes: Zero wait AHB-Lite slave
// Notes:   Shadow fields mirror register writes
`timescale 1ns/10ps

module cpp_top_asserts (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // AHB-Lite
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Audio and pin
  input wire logic [15:0] tx_audio,
  input wire logic [15:0] rx_audio,
  input wire logic        irq_req,
  input wire logic        call_progress_out,
  input wire logic        soft_reset_out
);
  import cpp_pkg::*;
  logic        ap_v_r, ap_w_r, sr_r, en_r, irq_r;
  logic [1:0]  md_r;
  logic [31:0] ap_a_r;
  // Data phase decodes
  wire wr_c1 = ap_v_r && ap_w_r && ap_a_r == 32'h4;
  wire wr_c2 = ap_v_r && ap_w_r && ap_a_r == 32'h8;
  wire rd_c1 = ap_v_r && !ap_w_r && ap_a_r == 32'h4;
  wire rd_un = ap_v_r && !ap_w_r && !(ap_a_r inside {32'h4, 32'h8, 32'h100});
  // Address capture and shadow fields
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {ap_v_r, ap_w_r, ap_a_r, sr_r, en_r, md_r, irq_r} <= '0;
    end else begin
      ap_v_r <= hsel && hready && htrans == 2'h2;
      ap_w_r <= hwrite;
      ap_a_r <= haddr;
      sr_r   <= wr_c1 && hwdata[7];
      if (wr_c1) {en_r, md_r} <= {hwdata[3], hwdata[5:4]};
      if (wr_c2) irq_r <= hwdata[7];
      if (soft_reset_out) {en_r, md_r, irq_r} <= '0;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence pin_low_s;
    (!call_progress_out) [*4];
  endsequence
  rdy_okay_a: assert property (hreadyout && !hresp) else $error("bus not ready or error");
  sr_match_a: assert property (soft_reset_out == sr_r) else $error("soft reset pulse wrong");
  sr_pulse_a: assert property (soft_reset_out |=> !soft_reset_out) else $error("long pulse");
  sr_clear_a: assert property (soft_reset_out |-> ##2 pin_low_s) else $error("pin kept");
  c1_zero_a: assert property (rd_c1 |-> (hrdata & 32'hFFFFFFC7) == 32'h0)
    else $error("unused control bits set");
  unmap_zero_a: assert property (rd_un |-> hrdata == 32'h0) else $error("unmapped not 0");
  irq_pass_a: assert property (irq_r && !soft_reset_out |=> call_progress_out == $past(irq_req))
    else $error("pin not irq");
  off_zero_a: assert property (!irq_r && (!en_r || md_r == 2'h3) |=> !call_progress_out)
    else $error("pin active when off");
endmodule // cpp_top_asserts

bind cpp_top cpp_top_asserts u_chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hreadyout, .hrdata, .hresp, .tx_audio, .rx_audio, .irq_req,
  .call_progress_out, .soft_reset_out);

// >>> bench/cpp_spk_model.sv
// Purpose: Filter and speaker seen from the output pin
// Assumes: Pin is a CMOS digital level
// Notes:   Counts high cycles as the filter averages them
`timescale 1ns/10ps

module cpp_spk_model (
  // Clock and control
  input  wire logic hclk,
  input  wire logic clr,
  // Pin and integral
  input  wire logic call_progress_out,
  output int        ones
);
  // Integrator of the pulse stream
  always @(posedge hclk) ones <= clr ? 0 : ones + int'(call_progress_out);
endmodule // cpp_spk_model

// >>> bench/call_progress_pwm_control_tb.sv
// Purpose: Self-checking bench for cpp_top
// Assumes: hready looped from hreadyout
// Notes:   Density checked over two sample periods
`timescale 1ns/10ps

module call_progress_pwm_control_tb;
  import cpp_pkg::*;
  logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, irq_req = 0, rdp = 0, clr = 1;
  logic [31:0] haddr = 0, hwdata = 0;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = 3'h2;
  logic [15:0] tx_audio = 0, rx_audio = 0;
  wire         hreadyout, hresp, call_progress_out, soft_reset_out;
  wire  [31:0] hrdata;
  int          ones, err_count = 0, tests_run = 0;
  logic [31:0] exp_q[$];
  cpp_top dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .tx_audio, .rx_audio, .irq_req,
    .call_progress_out, .soft_reset_out);
  cpp_spk_model spk (.hclk, .clr, .call_progress_out, .ones);
  task automatic finish_test;
    $display("err_count=%0d tests_run=%0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_near(input longint got, input longint exp, input longint tol);
    tests_run++;
    if (got > exp + tol || got + tol < exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Single AHB-Lite transfer, held until hready
  task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0;
    htrans <= 2'h0;
    hwdata <= d;
    rdp <= !w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdp <= 0;
  endtask
  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    ahb(1'b0, a, 32'h0);
  endtask
  // Read monitor against oldest note
  always @(posedge hclk) if (rdp && hreadyout === 1'b1) cmp(hrdata, exp_q.pop_front());
  initial begin
    forever #4 hclk = ~hclk;
  end
  initial begin
    #790000; // Above the 94,200 cycles the tests need
    err_count++;
    finish_test;
  end
  initial begin
    int t, r;
    longint s, x, e;
    void'($urandom(86213));
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    rd(32'h4, 32'h0);
    rd(32'h8, 32'h0);
    rd(32'hC, 32'h0);
    rd(32'h5, 32'h0);
    ahb(1'b1, 32'h4, 32'h7F);
    rd(32'h4, 32'h38);
    // Each waveform code, random steady audio
    for (int m = 0; m < 4; m++) begin
      t = $urandom_range(8191);
      r = $urandom_range(8191);
      tx_audio <= 16'(t - 4096);
      rx_audio <= 16'(r - 4096);
      s = t + r - 8192 + 32768;
      x = s >> 7;
      ahb(1'b1, 32'h4, 32'h8 | (m << 4));
      repeat (7900) @(posedge hclk);
      clr <= 0;
      repeat (15625) @(posedge hclk);
      clr <= 1;
      @(negedge hclk);
      e = m == 0 ? s * 15625 / 65536 : m == 1 ? x * 15625 / 512 : m == 2 ? (511 - x) * 15625 / 512 : 0;
      cmp_near(ones, e, m == 3 ? 0 : 160);
    end
    // Pin routed to interrupt
    ahb(1'b1, 32'h8, 32'h80);
    rd(32'h8, 32'h80);
    repeat (40) begin
      @(posedge hclk);
      irq_req <= 1'($urandom);
    end
    @(posedge hclk);
    irq_req <= 1;
    repeat (3) @(posedge hclk);
    cmp(32'(call_progress_out), 32'h1);
    // Soft reset restores defaults
    ahb(1'b1, 32'h4, 32'h80);
    rd(32'h4, 32'h0);
    rd(32'h8, 32'h0);
    rd(32'h100, 32'h80000000);
    finish_test;
  end
endmodule // call_progress_pwm_control_tb
